//--- rtl/ttc_pkg.sv
package ttc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_TIMER01_MODE = 8'h00;
  localparam logic [7:0] OFS_TIMER01_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TIMER2_AUX_MODE = 8'h08;
  localparam logic [7:0] OFS_TIMER2_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_TIMER0_COUNT = 8'h10;
  localparam logic [7:0] OFS_TIMER1_COUNT = 8'h14;
  localparam logic [7:0] OFS_TIMER2_COUNT = 8'h18;
  localparam logic [7:0] OFS_TIMER2_RELOAD = 8'h1C;
  localparam logic [7:0] OFS_SPEED_CONFIG = 8'h20;
  // timer01_mode nibble fields; timer 1 nibble sits at bit 4
  localparam int TIMER01_MODE_T1_SHIFT = 4;
  localparam int TIMER01_MODE_GATE = 3;
  localparam int TIMER01_MODE_FUNC = 2;
  localparam int TIMER01_MODE_MODE_HIGH = 1;
  localparam int TIMER01_MODE_MODE_LOW = 0;
  // timer01_control fields
  localparam int TIMER01_CONTROL_TF1 = 7;
  localparam int TIMER01_CONTROL_TR1 = 6;
  localparam int TIMER01_CONTROL_TF0 = 5;
  localparam int TIMER01_CONTROL_TR0 = 4;
  localparam int TIMER01_CONTROL_IE1 = 3;
  localparam int TIMER01_CONTROL_IT1 = 2;
  localparam int TIMER01_CONTROL_IE0 = 1;
  localparam int TIMER01_CONTROL_IT0 = 0;
  // timer2_aux_mode fields
  localparam int TIMER2_AUX_MODE_OE = 1;
  localparam int TIMER2_AUX_MODE_TIMER2_DOWN_COUNT_ENABLE = 0;
  // timer2_control fields
  localparam int TIMER2_CONTROL_TF2 = 7;
  localparam int TIMER2_CONTROL_TIMER2_EXTERNAL_FLAG = 6;
  localparam int TIMER2_CONTROL_RXSEL = 5;
  localparam int TIMER2_CONTROL_TXSEL = 4;
  localparam int TIMER2_CONTROL_EXEN = 3;
  localparam int TIMER2_CONTROL_RUN = 2;
  localparam int TIMER2_CONTROL_FUNC = 1;
  localparam int TIMER2_CONTROL_CPRL = 0;
  // speed config field: 1 selects 12 clocks per machine cycle
  localparam int SPEED_12T = 0;
  // Reset values
  localparam logic [7:0] RST_TIMER01_MODE = 8'h00;
  localparam logic [7:0] RST_TIMER01_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER2_AUX_MODE = 8'h00;
  localparam logic [7:0] RST_TIMER2_CONTROL = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_SPEED_CONFIG = 8'h01;
  // Mode field encodings
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // Machine cycle length in oscillator periods
  localparam logic [3:0] MC_LEN_12T = 4'hC;
  localparam logic [3:0] MC_LEN_6T = 4'h6;
  localparam logic [15:0] T2_DOWN_LOAD = 16'hFFFF;
  localparam int PIN_COUNT = 6;
endpackage

//--- rtl/ttc_pin_sync.sv
module ttc_pin_sync
  import ttc_pkg::*;
#(
  parameter int W = PIN_COUNT
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] stage1;

  // Pins idle high, so both stages reset high
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          stage1[i] <= 1'h1;
          pin_sync[i] <= 1'h1;
        end
        else
        begin
          stage1[i] <= pin_in[i];
          pin_sync[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule // ttc_pin_sync

//--- rtl/ttc_timers.sv
// Design decisions made here: the AHB-Lite slave port and the address map.
module ttc_timers
  import ttc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] count_pin,
  input wire logic [1:0] external_interrupt_pin_n,
  input wire logic timer2_trigger_pin,
  input wire logic vector_ack_timer0,
  input wire logic vector_ack_timer1,
  input wire logic vector_ack_ext0,
  input wire logic vector_ack_ext1,
  output logic timer0_irq,
  output logic timer1_irq,
  output logic ext_irq0,
  output logic ext_irq1,
  output logic timer2_irq,
  output logic serial_rx_clock,
  output logic serial_tx_clock,
  output logic clock_output_pin
);

  function automatic logic [16:0] step01(input logic [1:0] mode,
                                         input logic [15:0] cnt);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = {1'h0, cnt[15:8], cnt[4:0]} + 14'h1;
    c16 = {1'h0, cnt} + 17'h1;
    c8 = {1'h0, cnt[7:0]} + 9'h1;
    unique case (mode)
      MODE_13BIT: step01 = {c13[13], c13[12:5], cnt[7:5], c13[4:0]};
      MODE_16BIT: step01 = c16;
      MODE_8BIT_RELOAD:
        step01 = {c8[8], cnt[15:8], c8[8] ? cnt[15:8] : c8[7:0]};
      MODE_SPLIT: step01 = {1'h0, cnt};
    endcase
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:8] == 24'h0) && (a[1:0] == 2'h0) &&
             (a[7:0] <= OFS_SPEED_CONFIG);
  endfunction

  logic [5:0] pin_sync;
  logic [5:0] sample;
  logic [5:0] fall;
  logic [3:0] presc;
  logic [3:0] mc_len;
  logic mc_tick;
  logic dp_wr;
  logic [7:0] dp_addr;
  logic [7:0] timer01_mode;
  logic [7:0] timer2_aux_mode;
  logic [7:0] speed;
  logic tf1, tr1, tf0, tr0, ie1, it1, ie0, it0;
  logic tf2, timer2_external_flag, rxsel, txsel, timer2_external_enable, tr2, ct2, cprl;
  logic [15:0] cnt0, cnt1, cnt2, rcap;
  logic [15:0] next_cnt0, next_cnt1, next_cnt2;
  logic ovf0, ovf0h, ovf1, ovf2_up, unf2, ovf2;
  logic run0, run1, inc0, inc1, inc2, split, brg, arud, up2, trig;
  logic clkout_mode;
  logic wr_timer01_mode, wr_timer01_control, wr_timer2_aux_mode, wr_timer2_control;
  logic wr_c0, wr_c1, wr_c2, wr_rcap, wr_speed;
  logic [31:0] next_rdata;

  ttc_pin_sync #(.W(PIN_COUNT)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .pin_in({timer2_trigger_pin, external_interrupt_pin_n, count_pin}),
    .pin_sync(pin_sync)
  );

  // Machine cycle prescaler
  assign mc_len = speed[SPEED_12T] ? MC_LEN_12T : MC_LEN_6T;
  assign mc_tick = (presc >= mc_len - 4'h1);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      presc <= 4'h0;
    else if (mc_tick)
      presc <= 4'h0;
    else
      presc <= presc + 4'h1;
  end

  // Once-per-cycle pin sample; fall is sample change 1 to 0
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sample <= 6'h3F;
    else if (mc_tick)
      sample <= pin_sync;
  end

  assign fall = {6{mc_tick}} & sample & ~pin_sync;

  // AHB-Lite slave, zero wait states, always OKAY
  assign hreadyout = 1'h1;
  assign hresp = 1'h0;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dp_wr <= 1'h0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0;
    end
    else
    begin
      dp_wr <= hsel && htrans[1] && hready && hwrite && mapped(haddr);
      dp_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
        hrdata <= mapped(haddr) ? next_rdata : 32'h0;
    end
  end

  always_comb
  begin
    next_rdata = 32'h0;
    unique case (haddr[7:0])
      OFS_TIMER01_MODE: next_rdata[7:0] = timer01_mode;
      OFS_TIMER01_CONTROL:
        next_rdata[7:0] = {tf1, tr1, tf0, tr0, ie1, it1, ie0, it0};
      OFS_TIMER2_AUX_MODE: next_rdata[7:0] = timer2_aux_mode;
      OFS_TIMER2_CONTROL:
        next_rdata[7:0] = {tf2, timer2_external_flag, rxsel, txsel, timer2_external_enable, tr2, ct2, cprl};
      OFS_TIMER0_COUNT: next_rdata[15:0] = cnt0;
      OFS_TIMER1_COUNT: next_rdata[15:0] = cnt1;
      OFS_TIMER2_COUNT: next_rdata[15:0] = cnt2;
      OFS_TIMER2_RELOAD: next_rdata[15:0] = rcap;
      OFS_SPEED_CONFIG: next_rdata[7:0] = speed;
      default: next_rdata = 32'h0;
    endcase
  end

  assign wr_timer01_mode = dp_wr && (dp_addr == OFS_TIMER01_MODE);
  assign wr_timer01_control = dp_wr && (dp_addr == OFS_TIMER01_CONTROL);
  assign wr_timer2_aux_mode = dp_wr && (dp_addr == OFS_TIMER2_AUX_MODE);
  assign wr_timer2_control = dp_wr && (dp_addr == OFS_TIMER2_CONTROL);
  assign wr_c0 = dp_wr && (dp_addr == OFS_TIMER0_COUNT);
  assign wr_c1 = dp_wr && (dp_addr == OFS_TIMER1_COUNT);
  assign wr_c2 = dp_wr && (dp_addr == OFS_TIMER2_COUNT);
  assign wr_rcap = dp_wr && (dp_addr == OFS_TIMER2_RELOAD);
  assign wr_speed = dp_wr && (dp_addr == OFS_SPEED_CONFIG);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      timer01_mode <= RST_TIMER01_MODE;
      timer2_aux_mode <= RST_TIMER2_AUX_MODE;
      speed <= RST_SPEED_CONFIG;
    end
    else
    begin
      if (wr_timer01_mode)
        timer01_mode <= hwdata[7:0];
      if (wr_timer2_aux_mode)
        timer2_aux_mode <= {6'h0, hwdata[TIMER2_AUX_MODE_OE], hwdata[TIMER2_AUX_MODE_TIMER2_DOWN_COUNT_ENABLE]};
      if (wr_speed)
        speed <= {7'h0, hwdata[SPEED_12T]};
    end
  end

  // Timers 0 and 1
  assign split = (timer01_mode[1:0] == MODE_SPLIT);
  assign run0 = tr0 && (!timer01_mode[TIMER01_MODE_GATE] || pin_sync[3]);
  assign run1 = tr1 &&
    (!timer01_mode[TIMER01_MODE_GATE + TIMER01_MODE_T1_SHIFT] || pin_sync[4]);
  assign inc0 = run0 && (timer01_mode[TIMER01_MODE_FUNC] ? fall[0] : mc_tick);
  assign inc1 = run1 && (timer01_mode[TIMER01_MODE_FUNC + TIMER01_MODE_T1_SHIFT] ?
    fall[1] : mc_tick);

  always_comb
  begin
    next_cnt0 = cnt0;
    ovf0 = 1'h0;
    ovf0h = 1'h0;
    next_cnt1 = cnt1;
    ovf1 = 1'h0;
    if (split)
    begin
      // Low byte: timer 0 controls; high byte: machine cycles, timer1 run
      if (inc0)
        {ovf0, next_cnt0[7:0]} = {1'h0, cnt0[7:0]} + 9'h1;
      if (tr1 && mc_tick)
        {ovf0h, next_cnt0[15:8]} = {1'h0, cnt0[15:8]} + 9'h1;
    end
    else if (inc0)
      {ovf0, next_cnt0} = step01(timer01_mode[1:0], cnt0);
    if (inc1)
      {ovf1, next_cnt1} = step01(timer01_mode[5:4], cnt1);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt0 <= RST_COUNT;
      cnt1 <= RST_COUNT;
    end
    else
    begin
      cnt0 <= wr_c0 ? hwdata[15:0] : next_cnt0;
      cnt1 <= wr_c1 ? hwdata[15:0] : next_cnt1;
    end
  end

  // timer01_control; hardware set wins over any clear
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      {tf1, tr1, tf0, tr0, ie1, it1, ie0, it0} <= RST_TIMER01_CONTROL;
    else
    begin
      if (wr_timer01_control)
      begin
        tr1 <= hwdata[TIMER01_CONTROL_TR1];
        tr0 <= hwdata[TIMER01_CONTROL_TR0];
        it1 <= hwdata[TIMER01_CONTROL_IT1];
        it0 <= hwdata[TIMER01_CONTROL_IT0];
      end
      if (split ? ovf0h : ovf1)
        tf1 <= 1'h1;
      else if (vector_ack_timer1)
        tf1 <= 1'h0;
      else if (wr_timer01_control)
        tf1 <= hwdata[TIMER01_CONTROL_TF1];
      if (ovf0)
        tf0 <= 1'h1;
      else if (vector_ack_timer0)
        tf0 <= 1'h0;
      else if (wr_timer01_control)
        tf0 <= hwdata[TIMER01_CONTROL_TF0];
      if (!it1)
        ie1 <= !pin_sync[4];
      else if (fall[4])
        ie1 <= 1'h1;
      else if (vector_ack_ext1)
        ie1 <= 1'h0;
      else if (wr_timer01_control)
        ie1 <= hwdata[TIMER01_CONTROL_IE1];
      if (!it0)
        ie0 <= !pin_sync[3];
      else if (fall[3])
        ie0 <= 1'h1;
      else if (vector_ack_ext0)
        ie0 <= 1'h0;
      else if (wr_timer01_control)
        ie0 <= hwdata[TIMER01_CONTROL_IE0];
    end
  end

  assign timer0_irq = tf0;
  assign timer1_irq = tf1;
  assign ext_irq0 = ie0;
  assign ext_irq1 = ie1;

  // Timer 2
  assign brg = rxsel || txsel;
  assign arud = timer2_aux_mode[TIMER2_AUX_MODE_TIMER2_DOWN_COUNT_ENABLE] && !cprl && !brg;
  assign up2 = !arud || pin_sync[5];
  assign inc2 = tr2 && (ct2 ? fall[2] : mc_tick);
  assign trig = fall[5] && timer2_external_enable;
  assign ovf2_up = inc2 && up2 && (cnt2 == 16'hFFFF);
  assign unf2 = inc2 && !up2 && (cnt2 == rcap);
  assign ovf2 = ovf2_up || unf2;
  assign clkout_mode = timer2_aux_mode[TIMER2_AUX_MODE_OE] && !ct2;

  always_comb
  begin
    next_cnt2 = cnt2;
    if (ovf2_up && (brg || !cprl))
      next_cnt2 = rcap;
    else if (unf2)
      next_cnt2 = T2_DOWN_LOAD;
    else if (inc2)
      next_cnt2 = up2 ? cnt2 + 16'h1 : cnt2 - 16'h1;
    if (trig && !brg && !cprl && !arud)
      next_cnt2 = rcap;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt2 <= RST_COUNT;
      rcap <= RST_COUNT;
      clock_output_pin <= 1'h0;
    end
    else
    begin
      cnt2 <= wr_c2 ? hwdata[15:0] : next_cnt2;
      if (trig && !brg && cprl)
        rcap <= cnt2;
      else if (wr_rcap)
        rcap <= hwdata[15:0];
      if (clkout_mode && ovf2)
        clock_output_pin <= !clock_output_pin;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      {tf2, timer2_external_flag, rxsel, txsel, timer2_external_enable, tr2, ct2, cprl} <= RST_TIMER2_CONTROL;
    else
    begin
      if (wr_timer2_control)
      begin
        {rxsel, txsel} <= hwdata[TIMER2_CONTROL_RXSEL:TIMER2_CONTROL_TXSEL];
        timer2_external_enable <= hwdata[TIMER2_CONTROL_EXEN];
        tr2 <= hwdata[TIMER2_CONTROL_RUN];
        ct2 <= hwdata[TIMER2_CONTROL_FUNC];
        cprl <= hwdata[TIMER2_CONTROL_CPRL];
      end
      if (ovf2 && !brg && !clkout_mode)
        tf2 <= 1'h1;
      else if (wr_timer2_control)
        tf2 <= hwdata[TIMER2_CONTROL_TF2];
      if (trig && !arud)
        timer2_external_flag <= 1'h1;
      else if (arud && ovf2)
        timer2_external_flag <= !timer2_external_flag;
      else if (wr_timer2_control)
        timer2_external_flag <= hwdata[TIMER2_CONTROL_TIMER2_EXTERNAL_FLAG];
    end
  end

  assign timer2_irq = tf2 || (timer2_external_flag && !arud);
  assign serial_rx_clock = rxsel ? ovf2 : ovf1;
  assign serial_tx_clock = txsel ? ovf2 : ovf1;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // In 12T mode tick only after twelve counted clocks; a speed change may cut a cycle
  a_mc_period: assert property (speed[SPEED_12T] && mc_tick
    |-> presc == MC_LEN_12T - 4'h1)
    else $error("machine cycle not 12 clocks");
  a_t0_timer_inc: assert property (tr0 && timer01_mode[3:0] == 4'h1 && mc_tick
    && !wr_c0 |=> cnt0 == $past(cnt0) + 16'h1)
    else $error("timer0 did not advance");
  a_counter_hold: assert property (tr0 && timer01_mode[3:0] == 4'h5
    && !fall[0] && !wr_c0 |=> $stable(cnt0))
    else $error("counter moved without pin fall");
  a_gate_hold: assert property (timer01_mode[TIMER01_MODE_GATE] && !pin_sync[3]
    && !split && !wr_c0 |=> $stable(cnt0))
    else $error("gated timer0 advanced");
  a_reload_8bit: assert property (timer01_mode[1:0] == MODE_8BIT_RELOAD && inc0
    && cnt0[7:0] == 8'hFF && !wr_c0 |=> cnt0[7:0] == $past(cnt0[15:8]) && tf0)
    else $error("8-bit reload failed");
  a_t1_stop: assert property (timer01_mode[5:4] == MODE_SPLIT && !wr_c1
    |=> $stable(cnt1))
    else $error("timer1 counted in stop mode");
  a_split_tf1: assert property (split && tr1 && mc_tick
    && cnt0[15:8] == 8'hFF && !wr_c0 |=> tf1)
    else $error("split high byte did not set flag");
  a_tf2_brg: assert property (brg && !tf2 && !wr_timer2_control |=> !tf2)
    else $error("timer2 flag set in baud mode");
  a_t2_down: assert property (arud && inc2 && !pin_sync[5]
    && cnt2 == rcap && !wr_c2 |=> cnt2 == 16'hFFFF)
    else $error("timer2 down underflow not loaded");
  a_clk_toggle: assert property (clkout_mode && ovf2
    |=> clock_output_pin != $past(clock_output_pin))
    else $error("clock output did not toggle");
  a_timer2_external_flag_quiet: assert property (arud && !tf2 |-> !timer2_irq)
    else $error("external flag requested in up/down mode");

  c_t0_overflow: cover property (ovf0 ##1 tf0);
  c_t2_capture: cover property (trig && cprl && !brg);
  c_clk_toggle: cover property (clkout_mode && ovf2);

endmodule // ttc_timers

//--- tb/ttc_pin_model.sv
module ttc_pin_model
(
  input wire logic mclk,
  output logic [2:0] count_pin,
  output logic [1:0] external_interrupt_pin_n,
  output logic timer2_trigger_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bits: 2..0 count, 4..3 interrupt, 5 trigger; idle high as pulled up
  logic [5:0] pins = 6'h3F;
  // Each phase outlasts a 12-clock machine cycle
  localparam int HOLD = 30;
  assign count_pin = pins[2:0];
  assign external_interrupt_pin_n = pins[4:3];
  assign timer2_trigger_pin = pins[5];
  task automatic set_pin(input int idx, input logic v);
    @(posedge mclk);
    pins[idx] <= v;
  endtask
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      set_pin(idx, 1'b0);
      repeat (HOLD) @(posedge mclk);
      set_pin(idx, 1'b1);
      repeat (HOLD) @(posedge mclk);
    end
  endtask
endmodule // ttc_pin_model

//--- tb/tb_top.sv
module tb_top;
  import ttc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ack = 4'h0;
  logic hreadyout, hresp, timer0_irq, timer1_irq, ext_irq0, ext_irq1;
  logic timer2_irq, serial_rx_clock, serial_tx_clock, clock_output_pin;
  logic [31:0] hrdata, rv;
  logic [2:0] count_pin;
  logic [1:0] external_interrupt_pin_n;
  logic timer2_trigger_pin;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int n, tg, tx, rx;

  always #5 mclk = ~mclk;

  ttc_timers dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .count_pin(count_pin),
    .external_interrupt_pin_n(external_interrupt_pin_n),
    .timer2_trigger_pin(timer2_trigger_pin), .vector_ack_timer0(ack[0]),
    .vector_ack_timer1(ack[1]), .vector_ack_ext0(ack[2]),
    .vector_ack_ext1(ack[3]), .timer0_irq(timer0_irq),
    .timer1_irq(timer1_irq), .ext_irq0(ext_irq0), .ext_irq1(ext_irq1),
    .timer2_irq(timer2_irq), .serial_rx_clock(serial_rx_clock),
    .serial_tx_clock(serial_tx_clock), .clock_output_pin(clock_output_pin));

  ttc_pin_model pins (.mclk(mclk), .count_pin(count_pin),
    .external_interrupt_pin_n(external_interrupt_pin_n),
    .timer2_trigger_pin(timer2_trigger_pin));

  task automatic results;
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] inr(input logic [31:0] v, input int lo,
                                      input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction

  // Single AHB-Lite word transfer; read data lands in rv
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task automatic pulse_ack(input int i);
    @(posedge mclk);
    ack[i] <= 1'b1;
    @(posedge mclk);
    ack[i] <= 1'b0;
  endtask

  // Counts clock-out toggles and serial clock pulses over k cycles
  task automatic watch(input int k);
    logic last;
    last = clock_output_pin;
    tg = 0;
    tx = 0;
    rx = 0;
    repeat (k)
    begin
      @(negedge mclk);
      tg += (clock_output_pin !== last);
      last = clock_output_pin;
      tx += (serial_tx_clock === 1'b1);
      rx += (serial_rx_clock === 1'b1);
    end
  endtask

  task automatic t_regs;
    for (int i = 0; i < 9; i++)
    begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", (i == 8) ? {24'h0, RST_SPEED_CONFIG} : 32'h0, rv);
    end
    xfer(1'b1, OFS_TIMER01_MODE, 32'hA5);
    xfer(1'b0, OFS_TIMER01_MODE, 32'h0);
    chk("mode readback", 32'hA5, rv);
    xfer(1'b1, 8'h40, 32'hFF);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rv);
  endtask

  task automatic t_rate;
    logic [15:0] pre [3] = '{16'hFFF0, 16'hFFF0, 16'hFF10};
    logic [7:0] md [3] = '{8'h01, 8'h01, 8'h00};
    int mc [3] = '{12, 6, 12};
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, OFS_SPEED_CONFIG, (mc[i] == 12) ? 32'h1 : 32'h0);
      xfer(1'b1, OFS_TIMER01_MODE, {24'h0, md[i]});
      xfer(1'b1, OFS_TIMER0_COUNT, {16'h0, pre[i]});
      xfer(1'b1, OFS_TIMER01_CONTROL, 32'h10);
      n = 0;
      while (timer0_irq !== 1'b1 && n < 400)
      begin
        @(negedge mclk);
        n++;
      end
      chk("t0 period", 32'h1, inr(n, 15 * mc[i] - 4, 16 * mc[i] + 4));
      xfer(1'b0, OFS_TIMER01_CONTROL, 32'h0);
      chk("t0 flags", 32'h30, rv);
      pulse_ack(0);
      tick(2);
      chk("t0 ack", 32'h0, {31'h0, timer0_irq});
      xfer(1'b1, OFS_TIMER01_CONTROL, 32'h0);
    end
  endtask

  task automatic t_reload;
    xfer(1'b1, OFS_TIMER01_MODE, 32'h02);
    xfer(1'b1, OFS_TIMER0_COUNT, 32'hF0FE);
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h10);
    tick(40);
    xfer(1'b0, OFS_TIMER0_COUNT, 32'h0);
    chk("reload high", 32'hF0, {24'h0, rv[15:8]});
    chk("reload low", 32'h1, inr(rv[7:0], 8'hF0, 8'hF3));
    chk("reload flag", 32'h1, {31'h0, timer0_irq});
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h0);
    xfer(1'b0, OFS_TIMER01_CONTROL, 32'h0);
    chk("sw clear", 32'h0, rv);
  endtask

  task automatic t_count_gate;
    xfer(1'b1, OFS_TIMER01_MODE, 32'h50);
    xfer(1'b1, OFS_TIMER1_COUNT, 32'h0);
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h40);
    pins.pulse(1, 5);
    xfer(1'b0, OFS_TIMER1_COUNT, 32'h0);
    chk("pin count", 32'h5, rv);
    xfer(1'b1, OFS_TIMER01_MODE, 32'h39);
    xfer(1'b1, OFS_TIMER0_COUNT, 32'h0);
    xfer(1'b1, OFS_TIMER1_COUNT, 32'h0);
    pins.set_pin(3, 1'b0);
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h50);
    tick(100);
    xfer(1'b0, OFS_TIMER0_COUNT, 32'h0);
    chk("gate closed", 32'h0, rv);
    pins.set_pin(3, 1'b1);
    tick(100);
    xfer(1'b0, OFS_TIMER0_COUNT, 32'h0);
    chk("gate open", 32'h1, inr(rv, 6, 10));
    xfer(1'b0, OFS_TIMER1_COUNT, 32'h0);
    chk("t1 stopped", 32'h0, rv);
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h0);
  endtask

  task automatic t_split;
    xfer(1'b1, OFS_TIMER01_MODE, 32'h03);
    xfer(1'b1, OFS_TIMER0_COUNT, 32'hFE00);
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h40);
    tick(40);
    xfer(1'b0, OFS_TIMER01_CONTROL, 32'h0);
    chk("split flag", 32'hC0, rv);
    xfer(1'b0, OFS_TIMER0_COUNT, 32'h0);
    chk("split high", 32'h1, inr(rv[15:8], 0, 2));
    chk("split low", 32'h0, {24'h0, rv[7:0]});
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h0);
    xfer(1'b1, OFS_TIMER01_MODE, 32'h0);
  endtask

  task automatic t_ext;
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h01);
    pins.pulse(3, 1);
    chk("edge flag", 32'h1, {31'h0, ext_irq0});
    pulse_ack(2);
    tick(2);
    chk("edge ack", 32'h0, {31'h0, ext_irq0});
    pins.set_pin(4, 1'b0);
    tick(10);
    chk("level low", 32'h1, {31'h0, ext_irq1});
    pins.set_pin(4, 1'b1);
    tick(10);
    chk("level high", 32'h0, {31'h0, ext_irq1});
    xfer(1'b1, OFS_TIMER01_CONTROL, 32'h0);
  endtask

  task automatic t_timer2;
    xfer(1'b1, OFS_TIMER2_CONTROL, 32'h0D);
    tick(30);
    pins.pulse(5, 1);
    xfer(1'b0, OFS_TIMER2_CONTROL, 32'h0);
    chk("capture flag", 32'h4D, rv);
    chk("t2 request", 32'h1, {31'h0, timer2_irq});
    xfer(1'b0, OFS_TIMER2_RELOAD, 32'h0);
    chk("captured", 32'h1, inr(rv, 1, 16'hFFFF));
    xfer(1'b1, OFS_TIMER2_CONTROL, 32'h05);
    pins.pulse(5, 1);
    xfer(1'b0, OFS_TIMER2_CONTROL, 32'h0);
    chk("trigger off", 32'h05, rv);
    xfer(1'b1, OFS_TIMER2_CONTROL, 32'h0);
    xfer(1'b1, OFS_TIMER2_COUNT, 32'h0100);
    xfer(1'b1, OFS_TIMER2_RELOAD, 32'h0);
    xfer(1'b1, OFS_TIMER2_AUX_MODE, 32'h01);
    pins.set_pin(5, 1'b0);
    xfer(1'b1, OFS_TIMER2_CONTROL, 32'h04);
    tick(120);
    xfer(1'b0, OFS_TIMER2_COUNT, 32'h0);
    chk("down count", 32'h1, inr(rv, 8'hF0, 8'hFF));
    pins.set_pin(5, 1'b1);
    xfer(1'b1, OFS_TIMER2_CONTROL, 32'h0);
    xfer(1'b1, OFS_TIMER2_AUX_MODE, 32'h02);
    xfer(1'b1, OFS_TIMER2_RELOAD, 32'hFFFC);
    xfer(1'b1, OFS_TIMER2_COUNT, 32'hFFFC);
    xfer(1'b1, OFS_TIMER2_CONTROL, 32'h04);
    watch(480);
    chk("clock toggles", 32'h1, inr(tg, 9, 11));
    xfer(1'b0, OFS_TIMER2_CONTROL, 32'h0);
    chk("clkout no flag", 32'h04, rv);
    xfer(1'b1, OFS_TIMER2_AUX_MODE, 32'h0);
    xfer(1'b1, OFS_TIMER2_CONTROL, 32'h14);
    watch(480);
    chk("tx pulses", 32'h1, inr(tx, 9, 11));
    chk("rx pulses", 32'h0, rx);
    xfer(1'b0, OFS_TIMER2_CONTROL, 32'h0);
    chk("baud no flag", 32'h14, rv);
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_rate();
    t_reload();
    t_count_gate();
    t_split();
    t_ext();
    t_timer2();
    results();
  end
endmodule // tb_top
